// *** verilog/ffoc_pkg.sv ***
// Constants, types and the default-offset decode shared by the flag offset control block.
package ffoc_pkg;

  // ==========================================================================
  // Widths.
  localparam int FFOC_DATA_W = 16;
  localparam int FFOC_OFS_W  = 12;
  localparam int FFOC_CNT_W  = 13;
  localparam int FFOC_ADDR_W = 4;
  localparam int FFOC_SYNC_N = 5;

  // ==========================================================================
  // Memory depths; the fall-through output register adds one word on top.
  localparam logic [12:0] FFOC_DEPTH_X9    = 13'h1000;
  localparam logic [12:0] FFOC_DEPTH_OTHER = 13'h0800;
  localparam logic [12:0] FFOC_ONE_WORD    = 13'h0001;
  localparam logic [12:0] FFOC_HALF_EXTRA  = 13'h0002;

  // ==========================================================================
  // Register offsets on the plain register port.
  localparam logic [3:0] FFOC_ADDR_EMPTY  = 4'h0;
  localparam logic [3:0] FFOC_ADDR_FULL   = 4'h1;
  localparam logic [3:0] FFOC_ADDR_STATUS = 4'h2;
  localparam logic [3:0] FFOC_ADDR_COUNT  = 4'h3;

  // ==========================================================================
  // Default offsets selectable at master reset.
  localparam logic [11:0] FFOC_OFS_1023 = 12'h3ff;
  localparam logic [11:0] FFOC_OFS_511  = 12'h1ff;
  localparam logic [11:0] FFOC_OFS_255  = 12'h0ff;
  localparam logic [11:0] FFOC_OFS_127  = 12'h07f;
  localparam logic [11:0] FFOC_OFS_63   = 12'h03f;
  localparam logic [11:0] FFOC_OFS_31   = 12'h01f;
  localparam logic [11:0] FFOC_OFS_15   = 12'h00f;
  localparam logic [11:0] FFOC_OFS_7    = 12'h007;
  localparam logic [11:0] FFOC_OFS_3    = 12'h003;

  // ==========================================================================
  // Reset values and flag pipeline depths.
  localparam logic [11:0] FFOC_RST_OFFSET = 12'h07f;
  localparam logic [12:0] FFOC_RST_COUNT  = 13'h0000;
  localparam logic [4:0]  FFOC_RST_SYNC   = 5'h00;
  localparam int          FFOC_OR_STAGES  = 3;
  localparam int          FFOC_IR_STAGES  = 2;

  // ==========================================================================
  // Bit positions of the pins inside the synchroniser vectors.
  localparam int FFOC_PIN_MRS  = 0;
  localparam int FFOC_PIN_LSEL = 1;
  localparam int FFOC_PIN_HI   = 2;
  localparam int FFOC_PIN_LO   = 3;
  localparam int FFOC_PIN_X9   = 4;

  // ==========================================================================
  // Control states, Gray coded.
  typedef enum logic [1:0] {
    FFOC_ST_MRESET = 2'b00,
    FFOC_ST_RUN    = 2'b01
  } ffoc_state_type;

  // Default offset chosen by load select, the two select pins and the bus sizing.
  function automatic logic [11:0] ffoc_default_offset(input logic lsel,
                                                      input logic hi,
                                                      input logic lo,
                                                      input logic x9);
    case ({lsel, hi, lo})
      3'b010:  ffoc_default_offset = FFOC_OFS_511;
      3'b001:  ffoc_default_offset = FFOC_OFS_255;
      3'b000:  ffoc_default_offset = FFOC_OFS_127;
      3'b011:  ffoc_default_offset = FFOC_OFS_63;
      3'b100:  ffoc_default_offset = x9 ? FFOC_OFS_1023 : FFOC_OFS_31;
      3'b110:  ffoc_default_offset = x9 ? FFOC_OFS_31 : FFOC_OFS_15;
      3'b101:  ffoc_default_offset = x9 ? FFOC_OFS_15 : FFOC_OFS_7;
      default: ffoc_default_offset = x9 ? FFOC_OFS_7 : FFOC_OFS_3;
    endcase
  endfunction

endpackage

// *** verilog/ffoc_flag_if.sv ***
// Interface carrying fill level, offsets and raw flags between control and comparator.
`timescale 1ns/100ps
interface ffoc_flag_if;
  import ffoc_pkg::*;
  logic [12:0] count;
  logic [11:0] empty_off;
  logic [11:0] full_off;
  logic        x9;
  logic        full_raw;
  logic        empty_raw;
  logic        paf_raw;
  logic        hf_raw;
  logic        pae_raw;

  modport ctrl (output count, empty_off, full_off, x9,
                input  full_raw, empty_raw, paf_raw, hf_raw, pae_raw);
  modport cmp  (input  count, empty_off, full_off, x9,
                output full_raw, empty_raw, paf_raw, hf_raw, pae_raw);
endinterface

// *** verilog/ffoc_flag_stage.sv ***
// Register pipeline that delays one status flag by a fixed number of stages.
`timescale 1ns/100ps
module ffoc_flag_stage
  import ffoc_pkg::*;
#(
  parameter int   STAGES    = 2,
  parameter logic RESET_VAL = 1'b0
) (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst,
  // Flag in and delayed flag out.
  input  wire logic flag_in,
  output logic      flag_out
);

  typedef struct packed {
    logic [STAGES-1:0] sh;
  } ffoc_stage_type;

  ffoc_stage_type st;
  ffoc_stage_type next_st;

  // ==========================================================================
  // Shift chain; every stage moves on every edge.
  always_comb begin
    next_st = st;
    next_st.sh[0] = flag_in;
    for (int i = 1; i < STAGES; i++) begin
      next_st.sh[i] = st.sh[i-1];
    end
  end

  // The chain resets to the flag's idle value so the output is defined at once.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st.sh <= {STAGES{RESET_VAL}};
    end else begin
      st <= next_st;
    end
  end

  assign flag_out = st.sh[STAGES-1];

endmodule

// *** verilog/ffoc_flag_cmp.sv ***
// Comparator turning fill level and offsets into raw fall-through status flags.
`timescale 1ns/100ps
module ffoc_flag_cmp
  import ffoc_pkg::*;
(
  // Fill level in, raw flags out.
  ffoc_flag_if.cmp flg
);

  logic [12:0] depth;
  logic [12:0] capacity;

  // ==========================================================================
  // Capacity is memory depth plus the output register word.
  always_comb begin
    depth    = flg.x9 ? FFOC_DEPTH_X9 : FFOC_DEPTH_OTHER;
    capacity = depth + FFOC_ONE_WORD;
  end

  // Full and empty are active high, almost full, half full and almost empty active low; the top inverts none, it stores the pin level.
  always_comb begin
    flg.full_raw  = (flg.count == capacity);
    flg.empty_raw = (flg.count == FFOC_RST_COUNT);
    // Almost full pin low from capacity minus full offset upward.
    flg.paf_raw   = (flg.count < (capacity - {1'b0, flg.full_off}));
    // Half full pin low from half depth plus two words upward.
    flg.hf_raw    = (flg.count < ({1'b0, depth[12:1]} + FFOC_HALF_EXTRA));
    // Almost empty pin low at empty offset plus one word or fewer.
    flg.pae_raw   = (flg.count > ({1'b0, flg.empty_off} + FFOC_ONE_WORD));
  end

endmodule

// *** verilog/ffoc_ctrl.sv ***
// Top of the flag offset control: offsets, fill level, fall-through flags, register port.
`timescale 1ns/100ps
module ffoc_ctrl
  import ffoc_pkg::*;
(
  // Clock and reset.
  input  wire logic        CLK,
  input  wire logic        RST,
  // Configuration pins sampled during master reset.
  input  wire logic        MASTER_RESET_N,
  input  wire logic        OFFSET_LOAD_SELECT,
  input  wire logic        DEFAULT_OFFSET_SEL_HI,
  input  wire logic        DEFAULT_OFFSET_SEL_LO,
  input  wire logic        X9_TO_X9_MODE,
  // Data traffic strobes from same-clock logic.
  input  wire logic        WRITE_ENABLE_N,
  input  wire logic        READ_ENABLE_N,
  // Register port.
  input  wire logic [3:0]  REG_ADDR,
  input  wire logic [15:0] REG_WDATA,
  input  wire logic        REG_WRITE,
  input  wire logic        REG_READ,
  output logic      [15:0] PARALLEL_DATA_OUT,
  // Status flags, pin levels.
  output logic             INPUT_READY_FLAG,
  output logic             OUTPUT_READY_FLAG,
  output logic             ALMOST_FULL_FLAG,
  output logic             HALF_FULL_FLAG,
  output logic             ALMOST_EMPTY_FLAG
);

  typedef struct packed {
    ffoc_state_type state;
    logic [4:0]     sync1;
    logic [4:0]     sync2;
    logic           load_serial;
    logic           x9;
    logic [11:0]    empty_off;
    logic [11:0]    full_off;
    logic [12:0]    count;
    logic [15:0]    rdata;
    logic           almost_full_flag;
    logic           hf;
    logic           almost_empty_flag;
  } ffoc_ctrl_type;

  ffoc_ctrl_type st;
  ffoc_ctrl_type next_st;
  ffoc_flag_if   flg ();

  logic        mrs_active;
  logic        wr_ok;
  logic        rd_ok;
  logic [11:0] dflt;

  // ==========================================================================
  // Comparator and flag pipelines.
  ffoc_flag_cmp u_cmp (
    .flg (flg.cmp)
  );

  // Input ready sits high when full; its idle level after reset is low.
  ffoc_flag_stage #(
    .STAGES    (FFOC_IR_STAGES),
    .RESET_VAL (1'b0)
  ) u_ir_stage (
    .clk      (CLK),
    .rst      (RST),
    .flag_in  (flg.full_raw),
    .flag_out (INPUT_READY_FLAG)
  );

  // Output ready sits high when empty, which is the state after reset.
  ffoc_flag_stage #(
    .STAGES    (FFOC_OR_STAGES),
    .RESET_VAL (1'b1)
  ) u_or_stage (
    .clk      (CLK),
    .rst      (RST),
    .flag_in  (flg.empty_raw),
    .flag_out (OUTPUT_READY_FLAG)
  );

  // ==========================================================================
  // Decoded control terms. Only the second synchroniser stage is looked at.
  always_comb begin
    mrs_active = !st.sync2[FFOC_PIN_MRS];
    dflt       = ffoc_default_offset(st.sync2[FFOC_PIN_LSEL], st.sync2[FFOC_PIN_HI],
                                     st.sync2[FFOC_PIN_LO], st.sync2[FFOC_PIN_X9]);
    // Full and empty come from the live count, not the delayed pins, so a
    // write or read is never let through on a stale flag.
    wr_ok      = (st.state == FFOC_ST_RUN) && !WRITE_ENABLE_N && !flg.full_raw;
    rd_ok      = (st.state == FFOC_ST_RUN) && !READ_ENABLE_N && !flg.empty_raw;
  end

  assign flg.count     = st.count;
  assign flg.empty_off = st.empty_off;
  assign flg.full_off  = st.full_off;
  assign flg.x9        = st.x9;

  // ==========================================================================
  // Next-state logic for configuration, offsets, fill level and read data.
  always_comb begin
    next_st = st;
    next_st.sync1 = {X9_TO_X9_MODE, DEFAULT_OFFSET_SEL_LO, DEFAULT_OFFSET_SEL_HI,
                     OFFSET_LOAD_SELECT, MASTER_RESET_N};
    next_st.sync2 = st.sync1;
    next_st.almost_full_flag   = flg.paf_raw;
    next_st.hf    = flg.hf_raw;
    next_st.almost_empty_flag   = flg.pae_raw;
    next_st.rdata = '0;
    case (st.state)
      FFOC_ST_MRESET: begin
        if (!mrs_active) begin
          next_st.state = FFOC_ST_RUN;
        end
      end
      FFOC_ST_RUN: begin
        if (mrs_active) begin
          next_st.state = FFOC_ST_MRESET;
        end
      end
      default: begin
        next_st.state = FFOC_ST_MRESET;
      end
    endcase
    if (mrs_active) begin
      // Configuration follows the pins for the whole reset and freezes at release.
      next_st.load_serial = st.sync2[FFOC_PIN_LSEL];
      next_st.x9          = st.sync2[FFOC_PIN_X9];
      next_st.empty_off   = dflt;
      next_st.full_off    = dflt;
      next_st.count       = FFOC_RST_COUNT;
    end else begin
      // Both loading methods land here; offsets above depth minus one are
      // accepted as written and simply give odd flag levels.
      if (REG_WRITE && (REG_ADDR == FFOC_ADDR_EMPTY)) begin
        next_st.empty_off = REG_WDATA[11:0];
      end
      if (REG_WRITE && (REG_ADDR == FFOC_ADDR_FULL)) begin
        next_st.full_off = REG_WDATA[11:0];
      end
      case ({wr_ok, rd_ok})
        2'b10:   next_st.count = st.count + FFOC_ONE_WORD;
        2'b01:   next_st.count = st.count - FFOC_ONE_WORD;
        default: next_st.count = st.count;
      endcase
    end
    // Offsets read back on the parallel output only; there is no serial path.
    if (REG_READ) begin
      case (REG_ADDR)
        FFOC_ADDR_EMPTY:  next_st.rdata = {4'h0, st.empty_off};
        FFOC_ADDR_FULL:   next_st.rdata = {4'h0, st.full_off};
        FFOC_ADDR_STATUS: next_st.rdata = {8'h00, st.load_serial, st.x9, OUTPUT_READY_FLAG,
                                           INPUT_READY_FLAG, st.almost_empty_flag, st.hf, st.almost_full_flag,
                                           mrs_active};
        FFOC_ADDR_COUNT:  next_st.rdata = {3'h0, st.count};
        default:          next_st.rdata = '0;
      endcase
    end
  end

  // ==========================================================================
  // State register. Offsets take a plain value until the first master reset.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st.state       <= FFOC_ST_MRESET;
      st.sync1       <= FFOC_RST_SYNC;
      st.sync2       <= FFOC_RST_SYNC;
      st.load_serial <= 1'b0;
      st.x9          <= 1'b0;
      st.empty_off   <= FFOC_RST_OFFSET;
      st.full_off    <= FFOC_RST_OFFSET;
      st.count       <= FFOC_RST_COUNT;
      st.rdata       <= '0;
      st.almost_full_flag         <= 1'b1;
      st.hf          <= 1'b1;
      st.almost_empty_flag         <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign PARALLEL_DATA_OUT = st.rdata;
  assign ALMOST_FULL_FLAG  = st.almost_full_flag;
  assign HALF_FULL_FLAG    = st.hf;
  assign ALMOST_EMPTY_FLAG = st.almost_empty_flag;

  // ==========================================================================
  // Assertions.
  sequence s_read_full;
    flg.full_raw && rd_ok && !wr_ok;
  endsequence

  sequence s_first_write;
    flg.empty_raw && wr_ok && !mrs_active;
  endsequence

  property p_dflt_low;
    @(posedge CLK) disable iff (RST)
      (mrs_active && !st.sync2[FFOC_PIN_LSEL]) |=> (st.empty_off == $past(dflt));
  endproperty
  a_dflt_low: assert property (p_dflt_low) else $error("default offset wrong");

  property p_dflt_high;
    @(posedge CLK) disable iff (RST)
      (mrs_active && st.sync2[FFOC_PIN_LSEL]) |=> (st.full_off == $past(dflt));
  endproperty
  a_dflt_high: assert property (p_dflt_high) else $error("default offset wrong");

  // Absolute values, so a wrong entry in the shared decode cannot hide behind itself.
  property p_dflt_511;
    @(posedge CLK) disable iff (RST)
      (mrs_active && !st.sync2[FFOC_PIN_LSEL] && st.sync2[FFOC_PIN_HI] && !st.sync2[FFOC_PIN_LO])
        |=> (st.full_off == FFOC_OFS_511);
  endproperty
  a_dflt_511: assert property (p_dflt_511) else $error("default offset not 511");

  property p_dflt_1023;
    @(posedge CLK) disable iff (RST)
      (mrs_active && st.sync2[FFOC_PIN_LSEL] && !st.sync2[FFOC_PIN_HI] && !st.sync2[FFOC_PIN_LO]
        && st.sync2[FFOC_PIN_X9]) |=> (st.empty_off == FFOC_OFS_1023);
  endproperty
  a_dflt_1023: assert property (p_dflt_1023) else $error("default offset not 1023");

  property p_load_mode;
    @(posedge CLK) disable iff (RST)
      mrs_active |=> (st.load_serial == $past(st.sync2[FFOC_PIN_LSEL]));
  endproperty
  a_load_mode: assert property (p_load_mode) else $error("load mode not caught");

  property p_full_hold;
    @(posedge CLK) disable iff (RST)
      (flg.full_raw && READ_ENABLE_N && !mrs_active) |=> flg.full_raw;
  endproperty
  a_full_hold: assert property (p_full_hold) else $error("count passed capacity");

  property p_read_full;
    @(posedge CLK) disable iff (RST)
      s_read_full |-> ##3 !INPUT_READY_FLAG;
  endproperty
  a_read_full: assert property (p_read_full) else $error("input ready stuck");

  property p_empty_ignore;
    @(posedge CLK) disable iff (RST)
      (flg.empty_raw && WRITE_ENABLE_N && !mrs_active) |=> flg.empty_raw;
  endproperty
  a_empty_ignore: assert property (p_empty_ignore) else $error("read on empty");

  property p_or_stages;
    @(posedge CLK) disable iff (RST)
      ##3 (OUTPUT_READY_FLAG == $past(flg.empty_raw, 3));
  endproperty
  a_or_stages: assert property (p_or_stages) else $error("output ready delay");

  property p_ir_stages;
    @(posedge CLK) disable iff (RST)
      ##2 (INPUT_READY_FLAG == $past(flg.full_raw, 2));
  endproperty
  a_ir_stages: assert property (p_ir_stages) else $error("input ready delay");

  property p_pae_low;
    @(posedge CLK) disable iff (RST)
      ({1'b0, st.empty_off} + FFOC_ONE_WORD >= st.count) |=> !ALMOST_EMPTY_FLAG;
  endproperty
  a_pae_low: assert property (p_pae_low) else $error("almost empty level");

  property p_readback;
    @(posedge CLK) disable iff (RST)
      (REG_READ && REG_ADDR == FFOC_ADDR_FULL)
        |=> (PARALLEL_DATA_OUT == {4'h0, $past(st.full_off)});
  endproperty
  a_readback: assert property (p_readback) else $error("offset readback wrong");

  property p_reprogram;
    @(posedge CLK) disable iff (RST)
      (REG_WRITE && REG_ADDR == FFOC_ADDR_EMPTY && !mrs_active)
        |=> (st.empty_off == $past(REG_WDATA[11:0]));
  endproperty
  a_reprogram: assert property (p_reprogram) else $error("offset write lost");

  property p_first_word;
    @(posedge CLK) disable iff (RST)
      s_first_write |-> ##4 !OUTPUT_READY_FLAG [*1];
  endproperty
  a_first_word: assert property (p_first_word) else $error("output ready late");

endmodule

// *** dv/ffoc_traffic_model.sv ***
// Writer and reader logic model that strobes the block's data enables on command.
`timescale 1ns/100ps
module ffoc_traffic_model (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst,
  // Command from the bench.
  input  wire logic        go,
  input  wire logic        rd,
  input  wire logic        both,
  input  wire logic [12:0] n,
  input  wire logic        strap_en,
  input  wire logic        strap_lsel,
  // Pins towards the block, and busy back to the bench.
  output logic             write_enable_n,
  output logic             read_enable_n,
  output logic             load_select,
  output logic             busy
);
  logic [12:0] left;
  logic        mode;
  logic        dual;

  // ==========================================================================
  // One strobe a cycle with no gaps, even into a full or empty FIFO.
  // A dual command strobes write and read together in each of its cycles.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      left <= 13'h0000;
      mode <= 1'b0;
      dual <= 1'b0;
    end else if (go) begin
      left <= n;
      mode <= rd;
      dual <= both;
    end else if (left != 13'h0000) begin
      left <= left - 13'h0001;
    end
  end

  // ==========================================================================
  // Outside master reset the strap is held high so that data traffic is legal.
  assign load_select    = strap_en ? strap_lsel : 1'b1;
  assign busy           = (left != 13'h0000);
  assign write_enable_n = !(busy && (!mode || dual));
  assign read_enable_n  = !(busy && (mode || dual));
endmodule

// *** dv/ffoc_ctrl_tb_top.sv ***
// Self-checking testbench of the flag offset control with a traffic model.
`timescale 1ns/100ps
module ffoc_ctrl_tb_top;
  import ffoc_pkg::*;
  logic        clk;
  logic        rst;
  logic        mrn;
  logic        s_hi;
  logic        s_lo;
  logic        x9;
  logic        s_en;
  logic        s_ls;
  logic        lsel;
  logic        we_n;
  logic        re_n;
  logic [3:0]  ra;
  logic [15:0] wd;
  logic        rw;
  logic        rr;
  logic [15:0] pdo;
  logic        ir_f;
  logic        or_f;
  logic        paf_f;
  logic        hf_f;
  logic        pae_f;
  logic        go;
  logic        rd_c;
  logic        both_c;
  logic [12:0] n_c;
  logic        busy;
  logic        pend;
  logic [15:0] exp_q[$];
  int          n_fail;
  int          cmp_count;
  int          cnt;
  int          cap;
  int          eo;
  int          fo;
  logic        cx9;
  logic        cls;

  ffoc_ctrl dut (.CLK(clk), .RST(rst), .MASTER_RESET_N(mrn), .OFFSET_LOAD_SELECT(lsel),
    .DEFAULT_OFFSET_SEL_HI(s_hi), .DEFAULT_OFFSET_SEL_LO(s_lo), .X9_TO_X9_MODE(x9),
    .WRITE_ENABLE_N(we_n), .READ_ENABLE_N(re_n), .REG_ADDR(ra), .REG_WDATA(wd),
    .REG_WRITE(rw), .REG_READ(rr), .PARALLEL_DATA_OUT(pdo), .INPUT_READY_FLAG(ir_f),
    .OUTPUT_READY_FLAG(or_f), .ALMOST_FULL_FLAG(paf_f), .HALF_FULL_FLAG(hf_f),
    .ALMOST_EMPTY_FLAG(pae_f));

  ffoc_traffic_model peer (.clk(clk), .rst(rst), .go(go), .rd(rd_c), .both(both_c), .n(n_c),
    .strap_en(s_en), .strap_lsel(s_ls), .write_enable_n(we_n), .read_enable_n(re_n),
    .load_select(lsel), .busy(busy));

  // ==========================================================================
  // Clock at 200 MHz.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Comparison shared by every check.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Verdict and end of run.
  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Default offset from load select, the two select pins and bus sizing.
  function automatic int def_ofs(input logic s, input logic h, input logic l, input logic x);
    int t0[4];
    int t9[4];
    int to[4];
    t0 = '{127, 255, 511, 63};
    t9 = '{1023, 15, 31, 7};
    to = '{31, 7, 15, 3};
    if (!s)
      return t0[{h, l}];
    return x ? t9[{h, l}] : to[{h, l}];
  endfunction

  // Expected status word from the modelled fill level and offsets.
  function automatic logic [15:0] exp_st();
    logic [7:0] s;
    s = 8'h00;
    s[1] = !(cnt >= cap - fo);
    s[2] = !(cnt >= (cap - 1) / 2 + 2);
    s[3] = !(cnt <= eo + 1);
    s[4] = (cnt == cap);
    s[5] = (cnt == 0);
    s[6] = cx9;
    s[7] = cls;
    return {8'h00, s};
  endfunction

  // ==========================================================================
  // Register port cycles; a read notes its expected data for the monitor.
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    ra <= a;
    wd <= d;
    rw <= 1'b1;
    @(posedge clk);
    rw <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    ra <= a;
    rr <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    rr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe, zero otherwise.
  always @(negedge clk) begin
    if (pend)
      chk(pdo, exp_q.pop_front());
    else if (!rst)
      chk(pdo, 16'h0000);
    pend = rr;
  end

  // Master reset with straps held well before and after it.
  task automatic mreset(input logic h, input logic l, input logic s, input logic x);
    @(posedge clk);
    s_hi <= h;
    s_lo <= l;
    s_ls <= s;
    s_en <= 1'b1;
    x9 <= x;
    repeat (3) @(posedge clk);
    mrn <= 1'b0;
    repeat (3) @(posedge clk);
    mrn <= 1'b1;
    repeat (4) @(posedge clk);
    s_en <= 1'b0;
    repeat (2) @(posedge clk);
    cx9 = x;
    cls = s;
    cap = x ? 4097 : 2049;
    cnt = 0;
    eo = def_ofs(s, h, l, x);
    fo = eo;
  endtask

  // Move the fill level towards a target; strobes past full or empty are dropped.
  // A target equal to the level sends writes and reads together, which keep it except at empty or full.
  task automatic go_to(input int t);
    int k;
    int i;
    logic [15:0] e;
    k = (t == cnt) ? 4 : ((t > cnt) ? t - cnt : cnt - t);
    @(posedge clk);
    go <= 1'b1;
    rd_c <= (t < cnt);
    both_c <= (t == cnt);
    n_c <= k[12:0];
    @(posedge clk);
    go <= 1'b0;
    @(negedge clk);
    for (i = 0; i < 9000 && busy === 1'b1; i++)
      @(negedge clk);
    chk({15'h0000, busy}, 16'h0000);
    repeat (5) @(negedge clk);
    cnt = (t < 0) ? 0 : ((t > cap) ? cap : t);
    e = exp_st();
    chk({11'h000, ir_f, or_f, pae_f, hf_f, paf_f}, {11'h000, e[4], e[5], e[3:1]});
    rd(FFOC_ADDR_COUNT, {3'h0, cnt[12:0]});
    rd(FFOC_ADDR_STATUS, e);
  endtask

  // ==========================================================================
  // Main sequence.
  initial begin
    int i;
    int v;
    int w;
    int h;
    int lv[18];
    rst = 1'b1;
    mrn = 1'b1;
    s_hi = 1'b0;
    s_lo = 1'b0;
    s_ls = 1'b0;
    s_en = 1'b1;
    x9 = 1'b0;
    ra = 4'h0;
    wd = 16'h0000;
    rw = 1'b0;
    rr = 1'b0;
    go = 1'b0;
    rd_c = 1'b0;
    both_c = 1'b0;
    n_c = 13'h0000;
    pend = 1'b0;
    void'($urandom(7543));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    // Every strap combination in both bus sizings.
    for (i = 0; i < 16; i++) begin
      mreset(i[0], i[1], i[2], i[3]);
      rd(FFOC_ADDR_EMPTY, {4'h0, eo[11:0]});
      rd(FFOC_ADDR_FULL, {4'h0, fo[11:0]});
      rd(FFOC_ADDR_STATUS, exp_st());
    end
    // Reprogramming; upper bits, read-only and unmapped places ignored.
    v = $urandom % 4096;
    w = $urandom % 4096;
    wr(FFOC_ADDR_EMPTY, {4'hf, v[11:0]});
    wr(FFOC_ADDR_FULL, {4'ha, w[11:0]});
    wr(FFOC_ADDR_STATUS, 16'hffff);
    wr(4'h9, 16'hffff);
    eo = v;
    fo = w;
    rd(FFOC_ADDR_EMPTY, {4'h0, v[11:0]});
    rd(FFOC_ADDR_FULL, {4'h0, w[11:0]});
    rd(4'h9, 16'h0000);
    rd(FFOC_ADDR_STATUS, exp_st());
    // Fill past full and drain past empty at every flag boundary.
    for (i = 0; i < 2; i++) begin
      mreset(1'b0, 1'b0, 1'b1, i[0]);
      eo = $urandom % 200 + 2;
      fo = $urandom % 200 + 2;
      wr(FFOC_ADDR_EMPTY, eo[15:0]);
      wr(FFOC_ADDR_FULL, fo[15:0]);
      h = (cap - 1) / 2 + 2;
      lv = '{1, eo + 1, eo + 2, h - 1, h, h, cap - fo - 1, cap - fo, cap, cap + 3,
             cap - 1, cap - fo - 1, h - 1, eo + 2, eo + 1, 1, 0, -3};
      foreach (lv[j])
        go_to(lv[j]);
    end
    repeat (4) @(posedge clk);
    results();
  end

  // Watchdog well beyond the expected run length.
  initial begin
    #300000;
    n_fail++;
    results();
  end
endmodule
